// ==== verification/hbg_host_model.sv ====
// host pin model driving polarity, disable and enable pins
`timescale 1ns/10ps
module hbg_host_model (
  // clock
  input wire logic pclk,
  // commanded levels and float requests: en, dis, b, a
  input wire logic [3:0] lvl,
  input wire logic [3:0] flt,
  // pins and pad float indications
  output logic [3:0] pin,
  output logic [3:0] pin_float
);
  initial begin
    pin = 4'h0;
    pin_float = 4'h0;
  end
  // a floating pin toggles so that no stale level passes for a drive
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      pin[i] <= flt[i] ? ~pin[i] : lvl[i];
    end
    pin_float <= flt;
  end
endmodule // hbg_host_model

// ==== verification/tb_top.sv ====
// testbench for the h-bridge gate and fault logic
`timescale 1ns/10ps
module tb_top;
  import hbg_pkg::*;
  localparam int unsigned OFFC = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, oe_a, oe_b, out_a, out_b, flag_n, flag_oe_n, sleep_mode, irq, flag_pin;
  logic [3:0] lvl = 4'h0;
  logic [3:0] flt = 4'h0;
  logic [3:0] pin, pin_float;
  hbg_sense_t sense = '0;
  int miscompares = 0;
  int n_compared = 0;
  int k;
  always #50 pclk = ~pclk;
  // open-drain flag with pull-up
  assign flag_pin = flag_oe_n ? 1'b1 : flag_n;
  hbg_host_model host_u (.pclk(pclk), .lvl(lvl), .flt(flt), .pin(pin), .pin_float(pin_float));
  hbg_bridge #(.OFF_CYC(OFFC), .BLANK_CYC(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .polarity_input_a(pin[0]), .polarity_input_a_float(pin_float[0]),
    .polarity_input_b(pin[1]), .polarity_input_b_float(pin_float[1]), .disable_one_input(pin[2]),
    .disable_one_input_float(pin_float[2]), .enable_sleep_input(pin[3]),
    .enable_sleep_input_float(pin_float[3]), .sense(sense), .bridge_output_a(out_a),
    .bridge_output_a_oe_n(oe_a), .bridge_output_b(out_b), .bridge_output_b_oe_n(oe_b),
    .fault_flag_n(flag_n), .fault_flag_oe_n(flag_oe_n), .sleep_mode(sleep_mode), .irq(irq));
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    i = 0;
    while (pready !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    if (i == 20) begin
      miscompares++;
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pin levels need sync and output flop before they show
  task pins(input logic [3:0] l, input logic [3:0] f);
    lvl <= l;
    flt <= f;
    repeat (6) @(posedge pclk);
  endtask
  task drv(input logic oe, input logic [1:0] ab, input logic fl, input logic iq);
    @(negedge pclk);
    chk(32'({oe_a, oe_b, flag_pin, irq}), 32'({oe, oe, fl, iq}));
    if (!oe) chk(32'({out_b, out_a}), 32'(ab));
    @(posedge pclk);
  endtask
  // counts off cycles of the bridge after a one-cycle current pulse
  task offcnt(output int n);
    n = 0;
    repeat (16) begin
      @(negedge pclk);
      if (oe_a === 1'b1) n++;
    end
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, REG_IRQ_EN, 32'h0);
    chk(rd, 32'(IRQ_EN_RESET));
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (k = 0; k < 4; k++) begin
      pins({2'b10, 2'(k)}, 4'h0);
      drv(1'b0, 2'(k), 1'b1, 1'b0);
    end
    pins(4'hD, 4'h0);
    drv(1'b1, 2'b00, 1'b0, 1'b0);
    pins(4'h1, 4'h0);
    drv(1'b1, 2'b00, 1'b1, 1'b0);
    chk(32'(sleep_mode), 32'h1);
    pins(4'h8, 4'h1);
    drv(1'b0, 2'b01, 1'b1, 1'b0);
    pins(4'h8, 4'h4);
    drv(1'b1, 2'b00, 1'b0, 1'b0);
    pins(4'h9, 4'h0);
    apb(1'b1, REG_IRQ_EN, 32'hF);
    sense.undervolt <= 1'b1;
    repeat (6) @(posedge pclk);
    drv(1'b1, 2'b00, 1'b0, 1'b1);
    sense.undervolt <= 1'b0;
    repeat (6) @(posedge pclk);
    drv(1'b0, 2'b01, 1'b1, 1'b1);
    apb(1'b1, REG_IRQ_CLR, 32'hF);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_IRQ_EN, 32'h0);
    sense.short_circ <= 1'b1;
    repeat (10) @(posedge pclk);
    sense.short_circ <= 1'b0;
    repeat (6) @(posedge pclk);
    drv(1'b1, 2'b00, 1'b0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[ST_SC_BIT]), 32'h1);
    pins(4'hD, 4'h0);
    pins(4'h9, 4'h0);
    drv(1'b0, 2'b01, 1'b1, 1'b0);
    for (k = 0; k < 2; k++) begin
      sense.over_temp <= 1'b1;
      repeat (6) @(posedge pclk);
      drv(1'b1, 2'b00, 1'b0, 1'b0);
      sense.over_temp <= 1'b0;
      sense.temp_hyst_ok <= 1'(k);
      pins(4'hD, 4'h0);
      pins(4'h9, 4'h0);
      drv(k == 0, 2'b01, k != 0, 1'b0);
    end
    sense.over_temp <= 1'b1;
    sense.temp_hyst_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    sense.over_temp <= 1'b0;
    pins(4'h1, 4'h0);
    drv(1'b1, 2'b00, 1'b1, 1'b0);
    pins(4'h9, 4'h0);
    drv(1'b0, 2'b01, 1'b1, 1'b0);
    sense.cur_normal <= 1'b1;
    @(posedge pclk);
    sense.cur_normal <= 1'b0;
    offcnt(k);
    chk(32'(k >= OFFC && k <= OFFC + 1), 32'h1);
    for (int f = 1; f >= 0; f--) begin
      sense.above_fold <= 1'(f);
      sense.cur_fold <= 1'b1;
      @(posedge pclk);
      sense.cur_fold <= 1'b0;
      offcnt(k);
      chk(32'(k >= OFFC && k <= OFFC + 1), 32'(f));
    end
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'hE);
    sense.short_circ <= 1'b1;
    repeat (10) @(posedge pclk);
    sense.short_circ <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    drv(1'b0, 2'b01, 1'b1, 1'b0);
    end_of_test;
  end
endmodule // tb_top

// ==== verilog/hbg_bridge.sv ====
// gate control and fault logic for one h-bridge, with apb registers
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module hbg_bridge
  import hbg_pkg::*;
#(
  parameter int unsigned OFF_CYC = OFF_TIME_CYC,
  parameter int unsigned BLANK_CYC = BLANK_TIME_CYC
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins, each with a floating indication from the pad
  input wire logic polarity_input_a,
  input wire logic polarity_input_a_float,
  input wire logic polarity_input_b,
  input wire logic polarity_input_b_float,
  input wire logic disable_one_input,
  input wire logic disable_one_input_float,
  input wire logic enable_sleep_input,
  input wire logic enable_sleep_input_float,
  // analog sense comparators, asynchronous
  input wire hbg_sense_t sense,
  // bridge outputs: out is level, oe_n low while driven
  output logic bridge_output_a,
  output logic bridge_output_a_oe_n,
  output logic bridge_output_b,
  output logic bridge_output_b_oe_n,
  // open-drain fault flag: pin pulled low while fault_flag_oe_n is low
  output logic fault_flag_n,
  output logic fault_flag_oe_n,
  output logic sleep_mode,
  output logic irq
);

  localparam int CW = 16;
  localparam logic [CW-1:0] OFF_LOAD = CW'(OFF_CYC - 1);
  localparam logic [CW-1:0] BLANK_LOAD = CW'(BLANK_CYC - 1);

  // pin resolution: floating levels fall to their defaults
  logic pa_raw, pb_raw, dis_raw, en_raw;
  assign pa_raw = polarity_input_a_float ? 1'b1 : polarity_input_a;
  assign pb_raw = polarity_input_b_float ? 1'b1 : polarity_input_b;
  assign dis_raw = disable_one_input_float ? 1'b1 : disable_one_input;
  assign en_raw = enable_sleep_input_float ? 1'b0 : enable_sleep_input;

  logic pa_s, pb_s, dis_s, en_s;
  logic uv_s, sc_s, ot_s, hy_s, fold_s, lim_n_s, lim_f_s;
  hbg_sync #(.RESET_VAL(1'b1)) u_sync_pa (.pclk(pclk), .presetn(presetn), .din(pa_raw), .dout(pa_s));
  hbg_sync #(.RESET_VAL(1'b1)) u_sync_pb (.pclk(pclk), .presetn(presetn), .din(pb_raw), .dout(pb_s));
  hbg_sync #(.RESET_VAL(1'b1)) u_sync_dis (.pclk(pclk), .presetn(presetn), .din(dis_raw), .dout(dis_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_en (.pclk(pclk), .presetn(presetn), .din(en_raw), .dout(en_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_uv (.pclk(pclk), .presetn(presetn), .din(sense.undervolt), .dout(uv_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_sc (.pclk(pclk), .presetn(presetn), .din(sense.short_circ), .dout(sc_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_ot (.pclk(pclk), .presetn(presetn), .din(sense.over_temp), .dout(ot_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_hy (.pclk(pclk), .presetn(presetn), .din(sense.temp_hyst_ok), .dout(hy_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_fb (.pclk(pclk), .presetn(presetn), .din(sense.above_fold), .dout(fold_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_ln (.pclk(pclk), .presetn(presetn), .din(sense.cur_normal), .dout(lim_n_s));
  hbg_sync #(.RESET_VAL(1'b0)) u_sync_lf (.pclk(pclk), .presetn(presetn), .din(sense.cur_fold), .dout(lim_f_s));

  // edge detection on the synchronised levels
  logic dis_prev_q, en_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_prev_q <= 1'b1;
      en_prev_q <= 1'b0;
    end else begin
      dis_prev_q <= dis_s;
      en_prev_q <= en_s;
    end
  end
  logic dis_fall, en_rise;
  assign dis_fall = dis_prev_q & ~dis_s;
  assign en_rise = ~en_prev_q & en_s;

  // registers
  logic [31:0] ctrl_q;
  logic [EV_W-1:0] irq_stat_q, irq_en_q;
  logic wr_en;
  assign wr_en = psel & penable & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && paddr == REG_CTRL) begin
      ctrl_q <= pwdata;
    end
  end

  // blanking timer, current limit off time and latches
  logic sc_lat_q, ot_lat_q;
  logic [CW-1:0] blank_q, off_q;
  logic drive_on, lim_hit, sc_declared;
  logic a_high_q, b_high_q, drive_q;
  logic fold_used;

  assign fold_used = fold_s & ctrl_q[CTRL_FOLD_EN_BIT];
  assign lim_hit = drive_on & (fold_used ? lim_f_s : lim_n_s);
  assign sc_declared = sc_s & drive_on & (blank_q == '0);

  // short latch; a fresh short beats a clearing edge; reset is the power cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_lat_q <= 1'b0;
    end else if (sc_declared) begin
      sc_lat_q <= 1'b1;
    end else if (dis_fall || en_rise) begin
      sc_lat_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_lat_q <= 1'b0;
    end else if (ot_s) begin
      ot_lat_q <= 1'b1;
    end else if ((en_rise) || (dis_fall && hy_s)) begin
      ot_lat_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_q <= '0;
    end else if (lim_hit && off_q == '0) begin
      off_q <= OFF_LOAD;
    end else if (off_q != '0) begin
      off_q <= off_q - 1'b1;
    end
  end

  // drive decision
  logic sleep_w, fault_lat;
  assign sleep_w = ~en_s;
  assign fault_lat = sc_lat_q | ot_lat_q;
  assign drive_on = en_s & ~dis_s & ~uv_s & ~fault_lat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_high_q <= 1'b0;
      b_high_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      a_high_q <= pa_s;
      b_high_q <= pb_s;
      drive_q <= drive_on & (off_q == '0) & ~lim_hit;
    end
  end

  // any change of the drive pattern restarts blanking
  logic trans;
  assign trans = (drive_q != (drive_on & (off_q == '0) & ~lim_hit)) | (a_high_q != pa_s) | (b_high_q != pb_s);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_q <= BLANK_LOAD;
    end else if (trans) begin
      blank_q <= BLANK_LOAD;
    end else if (blank_q != '0) begin
      blank_q <= blank_q - 1'b1;
    end
  end

  assign bridge_output_a = a_high_q;
  assign bridge_output_b = b_high_q;
  assign bridge_output_a_oe_n = ~drive_q;
  assign bridge_output_b_oe_n = ~drive_q;

  // flag low for disable, undervoltage and latches; sleep wins and keeps it high
  logic flag_low_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_low_q <= 1'b0;
    end else begin
      flag_low_q <= en_s & (dis_s | uv_s | fault_lat);
    end
  end
  assign fault_flag_n = 1'b0;
  assign fault_flag_oe_n = ~flag_low_q;
  assign sleep_mode = sleep_w;

  // sticky events: set beats clear
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  assign ev = {lim_hit & (off_q == '0), ot_s & ~ot_lat_q, sc_declared, uv_s};
  assign clr = (wr_en && paddr == REG_IRQ_CLR) ? pwdata[EV_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= IRQ_EN_RESET;
    end else if (wr_en && paddr == REG_IRQ_EN) begin
      irq_en_q <= pwdata[EV_W-1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  // apb read: zero wait state, unmapped addresses answer slverr
  logic mapped;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_IRQ_STAT)
    || (paddr == REG_IRQ_EN) || (paddr == REG_IRQ_CLR);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL: prdata <= ctrl_q;
        REG_STATUS: prdata <= 32'(({flag_low_q, dis_s, sleep_w, off_q != '0, ot_lat_q, sc_lat_q, uv_s}));
        REG_IRQ_STAT: prdata <= 32'(irq_stat_q);
        REG_IRQ_EN: prdata <= 32'(irq_en_q);
        default: prdata <= '0;
      endcase
    end
  end

  // checks
  a_sc_latch_off: assert property (@(posedge pclk) disable iff (!presetn)
    sc_lat_q |=> bridge_output_a_oe_n && bridge_output_b_oe_n) else $error("outputs driven during short latch");
  a_sc_clear_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sc_lat_q) |-> $past(dis_fall) || $past(en_rise)) else $error("short latch cleared without edge");
  a_ot_latch_set: assert property (@(posedge pclk) disable iff (!presetn)
    ot_s |=> ot_lat_q) else $error("overtemperature not latched");
  a_ot_dis_hyst: assert property (@(posedge pclk) disable iff (!presetn)
    ot_lat_q && dis_fall && !hy_s && !en_rise |=> ot_lat_q) else $error("disable cleared hot latch");
  a_off_time_hold: assert property (@(posedge pclk) disable iff (!presetn)
    lim_hit && off_q == '0 |=> !drive_q [*2]) else $error("output on during off time");
  a_sleep_flag_high: assert property (@(posedge pclk) disable iff (!presetn)
    !en_s |=> fault_flag_oe_n && bridge_output_a_oe_n) else $error("sleep state wrong");
  a_uv_recover: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(uv_s) && en_s && !dis_s && !fault_lat && off_q == '0 && !lim_hit |=> drive_q) else $error("no uv recovery");
  a_follow_pol: assert property (@(posedge pclk) disable iff (!presetn)
    drive_on |=> bridge_output_a == $past(pa_s) && bridge_output_b == $past(pb_s)) else $error("polarity not followed");
  a_blank_guard: assert property (@(posedge pclk) disable iff (!presetn)
    trans |=> !sc_declared) else $error("short declared inside blanking");
  c_forward: cover property (@(posedge pclk) drive_q && a_high_q && !b_high_q);
  c_sc_clear: cover property (@(posedge pclk) sc_lat_q ##[1:50] !sc_lat_q);
  c_limit: cover property (@(posedge pclk) lim_hit ##1 off_q != '0);
  c_ot_hyst_clear: cover property (@(posedge pclk) ot_lat_q && dis_fall && hy_s ##1 !ot_lat_q);
  c_uv_recover: cover property (@(posedge pclk) $fell(uv_s) ##1 drive_q);

  // latch and clear ordering: a short still present must survive a clearing edge
  a_sc_latch_set: assert property (@(posedge pclk) disable iff (!presetn)
    sc_declared |=> sc_lat_q)
    else $error("short not latched");
  a_sc_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    sc_declared && (dis_fall || en_rise) |=> sc_lat_q)
    else $error("clearing edge beat a live short");
  a_ot_en_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ot_lat_q && en_rise && !ot_s |=> !ot_lat_q)
    else $error("enable rise left hot latch set");
  a_dis_outputs_off: assert property (@(posedge pclk) disable iff (!presetn)
    dis_s |=> bridge_output_a_oe_n && bridge_output_b_oe_n)
    else $error("outputs driven while disabled");
  a_dis_flag_low: assert property (@(posedge pclk) disable iff (!presetn)
    en_s && dis_s |=> !fault_flag_oe_n)
    else $error("flag high while disabled");
  a_uv_flag_low: assert property (@(posedge pclk) disable iff (!presetn)
    en_s && uv_s |=> !fault_flag_oe_n && bridge_output_a_oe_n)
    else $error("undervoltage not reported");
  // pin floats pass two sync flops and the output flop, so three edges
  a_float_dis_off: assert property (@(posedge pclk) disable iff (!presetn)
    disable_one_input_float |-> ##3 bridge_output_a_oe_n)
    else $error("floating disable left outputs on");
  a_float_pol_high: assert property (@(posedge pclk) disable iff (!presetn)
    polarity_input_a_float |-> ##3 bridge_output_a)
    else $error("floating polarity not high");
  a_fold_limit: assert property (@(posedge pclk) disable iff (!presetn)
    drive_on && fold_s && ctrl_q[CTRL_FOLD_EN_BIT] && lim_f_s |-> lim_hit)
    else $error("foldback limit ignored");
  a_sleep_outputs_off: assert property (@(posedge pclk) disable iff (!presetn)
    !en_s |=> bridge_output_b_oe_n)
    else $error("outputs driven in sleep");
  // a clear write in the same cycle as an event must not lose the event
  a_stat_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ev != '0 |=> (irq_stat_q & $past(ev)) == $past(ev))
    else $error("event lost against clear");

endmodule // hbg_bridge

// ==== verilog/hbg_pkg.sv ====
// package for the h-bridge gate and fault logic: register map, fields, timing
package hbg_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OFF_TIME_NS = 20_000;
  localparam int unsigned OFF_TIME_CYC = (OFF_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BLANK_TIME_NS = 2_000;
  localparam int unsigned BLANK_TIME_CYC = (BLANK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;

  // ctrl fields
  localparam int unsigned CTRL_FOLD_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // status / irq fields
  localparam int unsigned ST_UV_BIT = 0;
  localparam int unsigned ST_SC_BIT = 1;
  localparam int unsigned ST_OT_BIT = 2;
  localparam int unsigned ST_LIM_BIT = 3;
  localparam int unsigned ST_SLEEP_BIT = 4;
  localparam int unsigned ST_DIS_BIT = 5;
  localparam int unsigned ST_FLAG_BIT = 6;
  localparam int unsigned EV_W = 4;
  localparam logic [EV_W-1:0] IRQ_EN_RESET = 4'h0;

  typedef enum logic [1:0] {
    HBG_DRV_LOW,
    HBG_DRV_HIGH,
    HBG_DRV_OFF
  } hbg_drv_t;

  typedef struct packed {
    logic undervolt;
    logic short_circ;
    logic over_temp;
    logic temp_hyst_ok;
    logic above_fold;
    logic cur_normal;
    logic cur_fold;
  } hbg_sense_t;

endpackage

// ==== verilog/hbg_sync.sv ====
// two-flop synchroniser for one pin level
`timescale 1ns/10ps
module hbg_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level
  input wire logic din,
  output logic dout
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // hbg_sync
